// ===== core/ctlm_monitor.v
`timescale 1ns/1ns
`include "ctlm_map.vh"
module ctlm_monitor #(
  parameter [6:0] IWARN_RESET = `CTLM_IWARN_RST,
  parameter [6:0] OCF_RESET   = `CTLM_OCF_RST
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // Register command port
  input  wire        wr_en,
  input  wire        rd_en,
  input  wire [7:0]  cmd,
  input  wire [15:0] wr_data,
  output reg  [15:0] rd_data,
  // Measurements
  input  wire [6:0]  iout_meas,
  input  wire [7:0]  temp_meas,
  // Alert and output control
  output wire        smbalert_n,
  output wire        output_enable,
  output wire        soft_start,
  // Non-volatile store
  output reg         nv_store,
  output reg  [15:0] nv_iwarn,
  output reg  [15:0] nv_otf,
  output reg  [15:0] nv_otw
);

  // ==========================================
  // Limit registers, status flags and latches
  reg [6:0] iwarn_mant;
  reg [6:0] ocf_mant;
  reg [7:0] otf_mant;
  reg [7:0] otw_mant;
  reg       iwarn_flag;
  reg       otf_flag;
  reg       otw_flag;
  reg       ivd_flag;
  reg       temp_latch;
  reg       warn_latch;
  reg       ss_pulse;

  wire [15:0] iwarn_word;
  wire [15:0] otf_word;
  wire [15:0] otw_word;
  wire [7:0]  otf_rel;
  wire [7:0]  otw_rel;
  wire        wr_iwarn;
  wire        wr_otf;
  wire        wr_otw;
  wire        wr_ocf;
  wire        bad_iwarn;
  wire        bad_otf;
  wire        bad_otw;
  wire        bad_ocf;
  wire        clr;
  wire        iwarn_cond;
  wire        otf_cond;
  wire        otw_cond;
  wire [15:0] status_word;

  assign iwarn_word = {`CTLM_OC_EXP, 4'h0, iwarn_mant};
  assign otf_word = {8'h00, otf_mant};
  assign otw_word = {8'h00, otw_mant};

  assign otf_rel = (otf_mant > `CTLM_HYST) ? otf_mant - `CTLM_HYST : 8'h00;
  assign otw_rel = (otw_mant > `CTLM_HYST) ? otw_mant - `CTLM_HYST : 8'h00;

  assign wr_iwarn = wr_en && (cmd == `CTLM_CMD_IWARN_LIM);
  assign wr_otf = wr_en && (cmd == `CTLM_CMD_OT_FAULT);
  assign wr_otw = wr_en && (cmd == `CTLM_CMD_OT_WARN);
  assign wr_ocf = wr_en && (cmd == `CTLM_CMD_OC_FAULT);
  assign clr    = wr_en && (cmd == `CTLM_CMD_CLEAR);

  assign bad_iwarn = wr_iwarn && (wr_data[6:0] > ocf_mant);
  assign bad_otf = wr_otf && (wr_data[7:0] <= otw_mant);
  assign bad_otw = wr_otw && (wr_data[7:0] >= otf_mant);
  assign bad_ocf = wr_ocf && (wr_data[6:0] < iwarn_mant);

  assign iwarn_cond = iout_meas > iwarn_mant;
  assign otf_cond = temp_meas > otf_mant;
  assign otw_cond = temp_meas > otw_mant;

  // ==========================================
  // Limit write path
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      iwarn_mant <= IWARN_RESET;
      ocf_mant <= OCF_RESET;
      otf_mant <= `CTLM_OTF_RST;
      otw_mant <= `CTLM_OTW_RST;
    end else begin
      if (wr_iwarn && !bad_iwarn) begin
        iwarn_mant <= wr_data[6:0];
      end
      if (wr_ocf && !bad_ocf) begin
        ocf_mant <= wr_data[6:0];
      end
      if (wr_otf && !bad_otf) begin
        otf_mant <= wr_data[7:0];
      end
      if (wr_otw && !bad_otw) begin
        otw_mant <= wr_data[7:0];
      end
    end
  end

  // ==========================================
  // Status flags
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      iwarn_flag <= 1'b0;
      otf_flag   <= 1'b0;
      otw_flag   <= 1'b0;
      ivd_flag   <= 1'b0;
      temp_latch <= 1'b0;
      warn_latch <= 1'b0;
      ss_pulse   <= 1'b0;
    end else begin
      ss_pulse <= 1'b0;
      if (iwarn_cond) begin
        iwarn_flag <= 1'b1;
      end else if (clr) begin
        iwarn_flag <= 1'b0;
      end
      if (otf_cond) begin
        otf_flag <= 1'b1;
      end else if (clr) begin
        otf_flag <= 1'b0;
      end
      if (bad_iwarn || bad_otf || bad_otw || bad_ocf) begin
        ivd_flag <= 1'b1;
      end else if (clr) begin
        ivd_flag <= 1'b0;
      end
      if (otf_cond) begin
        temp_latch <= 1'b1;
      end else if (temp_latch && (temp_meas <= otf_rel)) begin
        temp_latch <= 1'b0;
        ss_pulse   <= 1'b1;
      end
      if (otw_cond) begin
        warn_latch <= 1'b1;
      end else if (warn_latch && (temp_meas <= otw_rel)) begin
        warn_latch <= 1'b0;
      end
      if (otw_cond) begin
        otw_flag <= 1'b1;
      end else if (clr && !warn_latch) begin
        otw_flag <= 1'b0;
      end
    end
  end

  assign output_enable = !temp_latch;
  assign soft_start    = ss_pulse;

  assign smbalert_n = !(iwarn_flag || otf_flag || otw_flag || ivd_flag);

  assign status_word = {1'b0, iwarn_flag, 6'h00, 1'b0, !output_enable, 3'h0,
                        otf_flag || otw_flag, ivd_flag, iwarn_flag};

  // ==========================================
  // Read path
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      case (cmd)
        `CTLM_CMD_IWARN_LIM: rd_data <= iwarn_word;
        `CTLM_CMD_OC_FAULT:  rd_data <= {`CTLM_OC_EXP, 4'h0, ocf_mant};
        `CTLM_CMD_OT_FAULT:  rd_data <= otf_word;
        `CTLM_CMD_OT_WARN:   rd_data <= otw_word;
        `CTLM_CMD_STAT_BYTE: rd_data <= {8'h00, status_word[7:0]};
        `CTLM_CMD_STAT_WORD: rd_data <= status_word;
        `CTLM_CMD_STAT_IOUT: rd_data <= {10'h000, iwarn_flag, 5'h00};
        `CTLM_CMD_STAT_TEMP: rd_data <= {8'h00, otf_flag, otw_flag, 6'h00};
        `CTLM_CMD_STAT_CML:  rd_data <= {9'h000, ivd_flag, 6'h00};
        default:             rd_data <= 16'h0000;
      endcase
    end
  end

  // ==========================================
  // Store to non-volatile copy
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nv_store <= 1'b0;
      nv_iwarn <= 16'h0000;
      nv_otf   <= 16'h0000;
      nv_otw   <= 16'h0000;
    end else begin
      nv_store <= 1'b0;
      if (wr_en && (cmd == `CTLM_CMD_STORE_ALL)) begin
        nv_store <= 1'b1;
        nv_iwarn <= iwarn_word;
        nv_otf   <= otf_word;
        nv_otw   <= otw_word;
      end
    end
  end

endmodule

// ===== pkg/ctlm_map.vh
`ifndef CTLM_MAP_VH
`define CTLM_MAP_VH
// ==========================================
// Command codes
`define CTLM_CMD_IWARN_LIM  8'h4a
`define CTLM_CMD_OT_FAULT   8'h4f
`define CTLM_CMD_OT_WARN    8'h51
`define CTLM_CMD_OC_FAULT   8'h46
`define CTLM_CMD_STORE_ALL  8'h15
`define CTLM_CMD_STAT_BYTE  8'h78
`define CTLM_CMD_STAT_WORD  8'h79
`define CTLM_CMD_STAT_IOUT  8'h7b
`define CTLM_CMD_STAT_TEMP  8'h7d
`define CTLM_CMD_STAT_CML   8'h7e
`define CTLM_CMD_CLEAR      8'h03
// ==========================================
// Fixed fields
`define CTLM_OC_EXP         5'h1f
`define CTLM_OC_MANT_W      7
`define CTLM_T_MANT_W       8
// ==========================================
// Reset values and hysteresis (30 A variant)
`define CTLM_IWARN_RST      7'h3c
`define CTLM_OCF_RST        7'h4e
`define CTLM_OTF_RST        8'h96
`define CTLM_OTW_RST        8'h7d
`define CTLM_HYST           8'h14
// ==========================================
// Status bit positions
`define CTLM_SB_NONE        0
`define CTLM_SB_CML         1
`define CTLM_SB_TEMP        2
`define CTLM_SW_IOUT        14
`define CTLM_SI_IWARN       5
`define CTLM_ST_OTF         7
`define CTLM_ST_OTW         6
`define CTLM_SC_IVD         6
`endif

// ===== tb/ctlm_host.sv
`timescale 1ns/1ns
// ====
// Host side of the command port
module ctlm_host (
  // Clock
  input  wire        mclk,
  // Command port
  output reg         wr_en = 1'b0,
  output reg         rd_en = 1'b0,
  output reg  [7:0]  cmd = 8'h00,
  output reg  [15:0] wr_data = 16'h0000,
  input  wire [15:0] rd_data
);
  task wr(input [7:0] c, input [15:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    cmd <= c;
    wr_data <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
    cmd <= ~c;
    wr_data <= ~d;
  endtask
  task rd(input [7:0] c, output [15:0] q);
    @(posedge mclk);
    rd_en <= 1'b1;
    cmd <= c;
    @(posedge mclk);
    rd_en <= 1'b0;
    cmd <= ~c;
    @(posedge mclk);
    @(negedge mclk);
    q = rd_data;
  endtask
endmodule

// ===== tb/ctlm_monitor_asserts.sv
`timescale 1ns/1ns
// ====
// Port checks
module ctlm_chk (
  // Clock and reset
  input wire        mclk,
  input wire        rst_n,
  // Command port
  input wire        wr_en,
  input wire        rd_en,
  input wire [7:0]  cmd,
  input wire [15:0] rd_data,
  // Watched outputs
  input wire        smbalert_n,
  input wire        output_enable,
  input wire        soft_start,
  input wire        nv_store
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_off; $fell(output_enable) |-> !smbalert_n; endproperty
  a_off: assert property (p_off) else $error("off without alert");
  property p_ss; $rose(output_enable) |-> soft_start; endproperty
  a_ss: assert property (p_ss) else $error("no soft start");
  property p_ssr; soft_start |-> $rose(output_enable); endproperty
  a_ssr: assert property (p_ssr) else $error("stray soft start");
  property p_ssp; soft_start |=> !soft_start && output_enable; endproperty
  a_ssp: assert property (p_ssp) else $error("soft start not a pulse");
  property p_nv; wr_en && cmd == 8'h15 |=> nv_store; endproperty
  a_nv: assert property (p_nv) else $error("no store");
  property p_nvp; nv_store |=> !nv_store; endproperty
  a_nvp: assert property (p_nvp) else $error("store not a pulse");
  property p_ocr; rd_en && cmd == 8'h4a |-> ##1 rd_data[15:7] == 9'h1f0; endproperty
  a_ocr: assert property (p_ocr) else $error("bad fixed bits");
  property p_tr; rd_en && (cmd == 8'h4f || cmd == 8'h51) |-> ##1 rd_data[15:8] == 8'h00;
  endproperty
  a_tr: assert property (p_tr) else $error("bad temp fixed bits");
endmodule
bind ctlm_monitor ctlm_chk ctlm_chk_i (.mclk, .rst_n, .wr_en, .rd_en, .cmd, .rd_data,
  .smbalert_n, .output_enable, .soft_start, .nv_store);

// ===== tb/ctlm_monitor_tb.sv
`timescale 1ns/1ns
module ctlm_monitor_tb;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [6:0]  iout_meas = 7'h00;
  reg  [7:0]  temp_meas = 8'h19;
  wire        wr_en, rd_en, smbalert_n, output_enable, soft_start, nv_store;
  wire [7:0]  cmd;
  wire [15:0] wr_data, rd_data, nv_iwarn, nv_otf, nv_otw;
  reg  [15:0] q;
  integer     error_cnt = 0;
  integer     compares = 0;
  always #5 mclk = ~mclk;
  ctlm_monitor ctlm_monitor_i (.mclk, .rst_n, .wr_en, .rd_en, .cmd, .wr_data, .rd_data,
    .iout_meas, .temp_meas, .smbalert_n, .output_enable, .soft_start, .nv_store,
    .nv_iwarn, .nv_otf, .nv_otw);
  ctlm_host ctlm_host_i (.mclk, .wr_en, .rd_en, .cmd, .wr_data, .rd_data);
  task chk(input [15:0] g, input [15:0] e);
    compares = compares + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task st(input [7:0] t, input [6:0] i);
    @(posedge mclk);
    temp_meas <= t;
    iout_meas <= i;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  task end_sim;
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ====
  // Scenarios
  task t_rst;
    ctlm_host_i.rd(8'h4a, q); chk(q, 16'hf83c);
    ctlm_host_i.rd(8'h4f, q); chk(q, 16'h0096);
    ctlm_host_i.rd(8'h51, q); chk(q, 16'h007d);
    chk({output_enable, smbalert_n}, 2'b11);
    $display("%m done");
  endtask
  task t_iout;
    ctlm_host_i.wr(8'h4a, 16'h07a8);
    ctlm_host_i.rd(8'h4a, q); chk(q, 16'hf828);
    st(8'h19, 7'h28); chk(smbalert_n, 1'b1);
    st(8'h19, 7'h29); chk(smbalert_n, 1'b0);
    ctlm_host_i.rd(8'h7b, q); chk(q & 16'h0020, 16'h0020);
    ctlm_host_i.rd(8'h79, q); chk(q & 16'h4001, 16'h4001);
    st(8'h19, 7'h00);
    ctlm_host_i.wr(8'h03, 16'h0000);
    $display("%m done");
  endtask
  task t_ord;
    ctlm_host_i.wr(8'h4a, 16'h007f);
    ctlm_host_i.rd(8'h4a, q); chk(q, 16'hf828);
    ctlm_host_i.rd(8'h7e, q); chk(q & 16'h0040, 16'h0040);
    ctlm_host_i.rd(8'h78, q); chk(q & 16'h0002, 16'h0002);
    chk(smbalert_n, 1'b0);
    ctlm_host_i.wr(8'h51, 16'h0096);
    ctlm_host_i.wr(8'h4f, 16'h007d);
    ctlm_host_i.rd(8'h51, q); chk(q, 16'h007d);
    ctlm_host_i.rd(8'h4f, q); chk(q, 16'h0096);
    ctlm_host_i.wr(8'h46, 16'h0010);
    ctlm_host_i.rd(8'h46, q); chk(q, 16'hf84e);
    ctlm_host_i.wr(8'h51, 16'hff78);
    ctlm_host_i.rd(8'h51, q); chk(q, 16'h0078);
    ctlm_host_i.wr(8'h51, 16'h007d);
    ctlm_host_i.rd(8'h51, q); chk(q, 16'h007d);
    ctlm_host_i.wr(8'h03, 16'h0000);
    $display("%m done");
  endtask
  task t_temp;
    st(8'h7e, 7'h00); chk({output_enable, smbalert_n}, 2'b10);
    ctlm_host_i.rd(8'h7d, q); chk(q & 16'h00c0, 16'h0040);
    st(8'h97, 7'h00); chk({output_enable, smbalert_n}, 2'b00);
    ctlm_host_i.rd(8'h7d, q); chk(q & 16'h0080, 16'h0080);
    ctlm_host_i.rd(8'h78, q); chk(q & 16'h0044, 16'h0044);
    st(8'h83, 7'h00); chk(output_enable, 1'b0);
    st(8'h82, 7'h00); chk({output_enable, soft_start}, 2'b11);
    st(8'h6a, 7'h00);
    ctlm_host_i.wr(8'h03, 16'h0000);
    ctlm_host_i.rd(8'h7d, q); chk(q & 16'h0040, 16'h0040);
    st(8'h69, 7'h00);
    ctlm_host_i.wr(8'h03, 16'h0000);
    ctlm_host_i.rd(8'h7d, q); chk(q & 16'h0040, 16'h0000);
    $display("%m done");
  endtask
  task t_save;
    ctlm_host_i.wr(8'h15, 16'h0000);
    @(negedge mclk);
    chk(nv_store, 1'b1);
    chk(nv_iwarn, 16'hf828);
    chk(nv_otf, 16'h0096);
    chk(nv_otw, 16'h007d);
    $display("%m done");
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_rst;
    t_iout;
    t_ord;
    t_temp;
    t_save;
    end_sim;
  end
endmodule
